// File: include/ppc_pkg.sv
package ppc_pkg;
  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DBR = 8'h00;
  localparam logic [7:0] OFF_DBF = 8'h04;
  localparam logic [7:0] OFF_FFA = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0c;
  localparam logic [7:0] OFF_STAT = 8'h10;
  // field layout
  localparam int DB_W = 8;
  localparam int FRAC_W = 4;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DBR_EN = 1;
  localparam int CTRL_DBF_EN = 2;
  localparam int CTRL_PS_LO = 4;
  localparam int STAT_ODD = 0;
  localparam int STAT_OUT_LO = 1;
  // reset values
  localparam logic [7:0] RST_DBR = 8'h00;
  localparam logic [7:0] RST_DBF = 8'h00;
  localparam logic [3:0] RST_FFA = 4'h0;
  localparam logic [5:0] RST_CTRL = 6'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // prescaler divide choices
  typedef enum logic [1:0] {PS_DIV1, PS_DIV2, PS_DIV4, PS_DIV8} ppc_presc_t;
endpackage : ppc_pkg

// File: include/ppc_pair_if.sv
`timescale 1ns/100ps
// one normal/complementary output pair and its commands
interface ppc_pair_if;
  logic tick;
  logic clear;
  logic rise;
  logic fall;
  logic dbr_en;
  logic dbf_en;
  logic [ppc_pkg::DB_W-1:0] dbr_len;
  logic [ppc_pkg::DB_W-1:0] dbf_len;
  logic pri;
  logic cmp;
  modport ctl (output tick, clear, rise, fall, dbr_en, dbf_en, dbr_len, dbf_len,
               input pri, cmp);
  modport pair (input tick, clear, rise, fall, dbr_en, dbf_en, dbr_len, dbf_len,
                output pri, cmp);
endinterface : ppc_pair_if

// File: logic/ppc_prescaler.sv
`timescale 1ns/100ps
// modulator clock tick: one aclk cycle in every 1, 2, 4 or 8
module ppc_prescaler (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire ppc_pkg::ppc_presc_t sel,
  output logic tick
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] last;

  // terminal count per choice
  always_comb begin
    unique case (sel)
      ppc_pkg::PS_DIV1: last = 3'h0;
      ppc_pkg::PS_DIV2: last = 3'h1;
      ppc_pkg::PS_DIV4: last = 3'h3;
      ppc_pkg::PS_DIV8: last = 3'h7;
    endcase
    tick = (cnt_r >= last);
    cnt_nxt = tick ? 3'h0 : cnt_r + 3'h1;
  end

  // divider counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : ppc_prescaler

// File: logic/ppc_pair.sv
`timescale 1ns/100ps
// one output pair: break-before-make sequencing with dead band
module ppc_pair (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // commands and outputs
  ppc_pair_if.pair p
);
  typedef enum logic [2:0] {ST_OFF, ST_PRI, ST_DBR, ST_CMP, ST_DBF} ppc_pst_t;
  ppc_pst_t st_r;
  ppc_pst_t st_nxt;
  logic [ppc_pkg::DB_W-1:0] cnt_r;
  logic [ppc_pkg::DB_W-1:0] cnt_nxt;

  // next state: the outgoing side drops before the incoming side rises; with that dead band off or zero both switch on the same edge
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (p.clear) begin
      st_nxt = ST_OFF;
      cnt_nxt = '0;
    end else if (p.rise) begin
      if (p.dbr_en && p.dbr_len != '0) begin
        st_nxt = ST_DBR;
        cnt_nxt = p.dbr_len;
      end else begin
        st_nxt = ST_PRI;
      end
    end else if (p.fall) begin
      if (p.dbf_en && p.dbf_len != '0) begin
        st_nxt = ST_DBF;
        cnt_nxt = p.dbf_len;
      end else begin
        st_nxt = ST_CMP;
      end
    end else if (p.tick && (st_r == ST_DBR || st_r == ST_DBF)) begin
      if (cnt_r == 8'h01) begin
        st_nxt = (st_r == ST_DBR) ? ST_PRI : ST_CMP;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_OFF;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // never both active: each is one state
  assign p.pri = (st_r == ST_PRI);
  assign p.cmp = (st_r == ST_CMP);
endmodule : ppc_pair

// File: logic/ppc_top.sv
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module ppc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ppc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ppc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // time-base events, one-cycle pulses on aclk
  input wire logic period_evt,
  input wire logic rise_evt,
  input wire logic fall_evt,
  // pwm outputs
  output logic pwm_out_primary_odd,
  output logic pwm_out_primary_even,
  output logic pwm_out_compl_odd,
  output logic pwm_out_compl_even
);
  localparam int NPAIR = 2;

  ////////////////////////////////////////////////////////////////////////////
  // register file state
  logic [ppc_pkg::DB_W-1:0] rising_deadband_time_r;
  logic [ppc_pkg::DB_W-1:0] rising_deadband_time_nxt;
  logic [ppc_pkg::DB_W-1:0] falling_deadband_time_r;
  logic [ppc_pkg::DB_W-1:0] falling_deadband_time_nxt;
  logic [ppc_pkg::FRAC_W-1:0] fractional_period_adjust_r;
  logic [ppc_pkg::FRAC_W-1:0] fractional_period_adjust_nxt;
  logic [5:0] ctrl_r;
  logic [5:0] ctrl_nxt;

  // bus handshake state
  logic aw_held_r;
  logic aw_held_nxt;
  logic w_held_r;
  logic w_held_nxt;
  logic [ppc_pkg::ADDR_W-1:0] waddr_r;
  logic [ppc_pkg::ADDR_W-1:0] waddr_nxt;
  logic [7:0] wbyte_r;
  logic [7:0] wbyte_nxt;
  logic wlane_r;
  logic wlane_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic do_write;

  // modulator state
  logic tick;
  logic odd_r;
  logic odd_nxt;
  logic [ppc_pkg::FRAC_W-1:0] frac_acc_r;
  logic [ppc_pkg::FRAC_W-1:0] frac_acc_nxt;
  logic stretch_r;
  logic stretch_nxt;
  logic rise_pend_r;
  logic rise_pend_nxt;
  logic fall_pend_r;
  logic fall_pend_nxt;
  logic issue;
  logic [3:0] out_r;
  logic [3:0] out_nxt;

  ppc_pair_if pr [NPAIR] ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode shared by reads and writes
  function automatic logic addr_ok(input logic [ppc_pkg::ADDR_W-1:0] a);
    addr_ok = (a == ppc_pkg::OFF_DBR) || (a == ppc_pkg::OFF_DBF) ||
              (a == ppc_pkg::OFF_FFA) || (a == ppc_pkg::OFF_CTRL) ||
              (a == ppc_pkg::OFF_STAT);
  endfunction : addr_ok

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    waddr_nxt = waddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (awvalid && awready) begin // address moves on valid and ready
      aw_held_nxt = 1'b1;
      waddr_nxt = awaddr;
    end
    if (wvalid && wready) begin // data moves on valid and ready
      w_held_nxt = 1'b1;
      wbyte_nxt = wdata[7:0];
      wlane_nxt = wstrb[0];
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_ok(waddr_r) ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // write handshake registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= '0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= ppc_pkg::RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      waddr_r <= waddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register updates; only byte lane 0 carries data
  always_comb begin
    rising_deadband_time_nxt = rising_deadband_time_r;
    falling_deadband_time_nxt = falling_deadband_time_r;
    fractional_period_adjust_nxt = fractional_period_adjust_r;
    ctrl_nxt = ctrl_r;
    if (do_write && wlane_r) begin
      unique case (waddr_r)
        ppc_pkg::OFF_DBR: rising_deadband_time_nxt = wbyte_r;
        ppc_pkg::OFF_DBF: falling_deadband_time_nxt = wbyte_r;
        ppc_pkg::OFF_FFA: fractional_period_adjust_nxt = wbyte_r[3:0];
        ppc_pkg::OFF_CTRL: ctrl_nxt = wbyte_r[5:0];
        default: ;
      endcase
    end
  end

  // register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rising_deadband_time_r <= ppc_pkg::RST_DBR;
      falling_deadband_time_r <= ppc_pkg::RST_DBF;
      fractional_period_adjust_r <= ppc_pkg::RST_FFA;
      ctrl_r <= ppc_pkg::RST_CTRL;
    end else begin
      rising_deadband_time_r <= rising_deadband_time_nxt;
      falling_deadband_time_r <= falling_deadband_time_nxt;
      fractional_period_adjust_r <= fractional_period_adjust_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read under way, answer one cycle after the address
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = addr_ok(araddr) ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
      unique case (araddr)
        ppc_pkg::OFF_DBR: rdata_nxt[7:0] = rising_deadband_time_r;
        ppc_pkg::OFF_DBF: rdata_nxt[7:0] = falling_deadband_time_r;
        ppc_pkg::OFF_FFA: rdata_nxt[3:0] = fractional_period_adjust_r;
        ppc_pkg::OFF_CTRL: rdata_nxt[5:0] = ctrl_r;
        ppc_pkg::OFF_STAT: begin
          rdata_nxt[ppc_pkg::STAT_ODD] = odd_r;
          rdata_nxt[ppc_pkg::STAT_OUT_LO +: 4] = out_r;
        end
        default: ;
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // read registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ppc_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ready pulses for one cycle, only while its channel has room
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      arready <= 1'b0;
    end else begin
      awready <= awvalid && !aw_held_r && !awready;
      wready <= wvalid && !w_held_r && !wready;
      arready <= arvalid && !rvalid_r && !arready;
    end
  end
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // modulator clock
  ppc_prescaler u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .sel(ppc_pkg::ppc_presc_t'(ctrl_r[ppc_pkg::CTRL_PS_LO +: 2])),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // period alternation, fraction dither and event hold until the next tick
  assign issue = tick && !stretch_r && ctrl_r[ppc_pkg::CTRL_EN];

  always_comb begin
    logic [ppc_pkg::FRAC_W:0] sum;
    sum = {1'b0, frac_acc_r} + {1'b0, fractional_period_adjust_r};
    odd_nxt = odd_r;
    frac_acc_nxt = frac_acc_r;
    stretch_nxt = stretch_r;
    rise_pend_nxt = rise_pend_r;
    fall_pend_nxt = fall_pend_r;
    // a fall waiting behind a rise stays pending for the next tick
    if (issue) begin
      rise_pend_nxt = 1'b0;
      fall_pend_nxt = fall_pend_r && rise_pend_r;
    end
    if (tick && stretch_r) begin
      stretch_nxt = 1'b0;
    end
    if (!ctrl_r[ppc_pkg::CTRL_EN]) begin
      odd_nxt = 1'b0;
      frac_acc_nxt = '0;
      stretch_nxt = 1'b0;
      rise_pend_nxt = 1'b0;
      fall_pend_nxt = 1'b0;
    end else begin
      if (period_evt) begin
        odd_nxt = !odd_r;
        frac_acc_nxt = sum[ppc_pkg::FRAC_W-1:0];
        if (sum[ppc_pkg::FRAC_W]) begin
          stretch_nxt = 1'b1;
        end
      end
      if (rise_evt) begin
        rise_pend_nxt = 1'b1;
      end
      if (fall_evt) begin
        fall_pend_nxt = 1'b1;
      end
    end
  end

  // modulator registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      odd_r <= 1'b0;
      frac_acc_r <= '0;
      stretch_r <= 1'b0;
      rise_pend_r <= 1'b0;
      fall_pend_r <= 1'b0;
    end else begin
      odd_r <= odd_nxt;
      frac_acc_r <= frac_acc_nxt;
      stretch_r <= stretch_nxt;
      rise_pend_r <= rise_pend_nxt;
      fall_pend_r <= fall_pend_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pair 0 serves odd periods, pair 1 even periods
  for (genvar g = 0; g < NPAIR; g++) begin : g_pair
    assign pr[g].tick = tick;
    assign pr[g].clear = !ctrl_r[ppc_pkg::CTRL_EN];
    assign pr[g].rise = issue && rise_pend_r && (odd_r == (g == 0));
    assign pr[g].fall = issue && fall_pend_r && !rise_pend_r &&
                        (odd_r == (g == 0));
    assign pr[g].dbr_en = ctrl_r[ppc_pkg::CTRL_DBR_EN];
    assign pr[g].dbf_en = ctrl_r[ppc_pkg::CTRL_DBF_EN];
    assign pr[g].dbr_len = rising_deadband_time_r;
    assign pr[g].dbf_len = falling_deadband_time_r;
    ppc_pair u_pair (
      .aclk(aclk),
      .aresetn(aresetn),
      .p(pr[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed pin mapping: a, e, b, f
  always_comb begin
    out_nxt = {pr[1].cmp, pr[1].pri, pr[0].cmp, pr[0].pri};
  end

  // output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_r <= 4'h0;
    end else begin
      out_r <= out_nxt;
    end
  end
  assign pwm_out_primary_odd = out_r[0];
  assign pwm_out_compl_odd = out_r[1];
  assign pwm_out_primary_even = out_r[2];
  assign pwm_out_compl_even = out_r[3];
endmodule : ppc_top

// File: sim/ppc_gate_model.sv
`timescale 1ns/100ps
// gate drivers of both bridges: flags a leg pair switched on together
module ppc_gate_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // gate inputs
  input wire logic gate_a,
  input wire logic gate_e,
  input wire logic gate_b,
  input wire logic gate_f,
  // sticky shoot-through flag
  output logic shoot_r
);
  logic shoot_nxt;
  // a bridge leg pair conducting together is a short
  always_comb begin
    shoot_nxt = shoot_r | (gate_a & gate_e) | (gate_b & gate_f);
  end
  always_ff @(posedge aclk) begin
    shoot_r <= aresetn ? shoot_nxt : 1'b0;
  end
endmodule : ppc_gate_model

// File: sim/ppc_checker.sv
`timescale 1ns/100ps
// watches bus answers and output pairs at the top ports
module ppc_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ppc_pkg::ADDR_W-1:0] araddr,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // outputs
  input wire logic pwm_out_primary_odd,
  input wire logic pwm_out_primary_even,
  input wire logic pwm_out_compl_odd,
  input wire logic pwm_out_compl_even
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ar_r;
  logic [7:0] ar_nxt;
  // address of the read in flight
  always_comb begin
    ar_nxt = (arvalid && arready) ? araddr : ar_r;
  end
  always_ff @(posedge aclk) begin
    ar_r <= ar_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_odd_apart: assert property (!(pwm_out_primary_odd && pwm_out_compl_odd))
    else $error("odd pair both active");
  a_even_apart: assert property (!(pwm_out_primary_even && pwm_out_compl_even))
    else $error("even pair both active");
  a_odd_alone: assert property ($rose(pwm_out_primary_odd) |-> !pwm_out_primary_even)
    else $error("odd primary rose beside even primary");
  a_even_alone: assert property ($rose(pwm_out_primary_even) |-> !pwm_out_primary_odd)
    else $error("even primary rose beside odd primary");
  a_bresp_held: assert property (bvalid && !bready |=> bvalid)
    else $error("write response withdrawn");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data withdrawn or changed");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered in one cycle");
  a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read upper bits not zero");
  a_frac_upper: assert property (rvalid && ar_r == ppc_pkg::OFF_FFA |-> rdata[7:4] == 4'h0)
    else $error("fraction upper bits not zero");
  a_err_nodata: assert property (rvalid && rresp == ppc_pkg::RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read carries data");
  c_odd: cover property ($rose(pwm_out_primary_odd));
  c_even: cover property ($rose(pwm_out_primary_even));
  c_err: cover property (rvalid && rresp == ppc_pkg::RESP_SLVERR);
endmodule : ppc_checker
bind ppc_top ppc_checker chk_u (.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid),
  .arready(arready),
  .araddr(araddr), .bvalid(bvalid), .bready(bready), .rvalid(rvalid), .rready(rready),
  .rdata(rdata), .rresp(rresp), .pwm_out_primary_odd(pwm_out_primary_odd),
  .pwm_out_primary_even(pwm_out_primary_even), .pwm_out_compl_odd(pwm_out_compl_odd),
  .pwm_out_compl_even(pwm_out_compl_even));

// File: sim/tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic period_evt, rise_evt, fall_evt;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, a_o, b_o, e_o, f_o, shoot;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] o = {f_o, b_o, e_o, a_o};
  int err_count, n_checks, d;
  logic [31:0] seed = 32'h711faf6d;
  logic [33:0] rq[$];
  logic [33:0] rx;
  ppc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .period_evt(period_evt), .rise_evt(rise_evt),
    .fall_evt(fall_evt), .pwm_out_primary_odd(a_o), .pwm_out_primary_even(b_o),
    .pwm_out_compl_odd(e_o), .pwm_out_compl_even(f_o));
  ppc_gate_model gate_u (.aclk(aclk), .aresetn(aresetn), .gate_a(a_o), .gate_e(e_o),
    .gate_b(b_o), .gate_f(f_o), .shoot_r(shoot));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // bus write; holds each channel until its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] st,
                    input logic [1:0] er);
    int t;
    logic g, w, b;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b = 1'b0;
    for (t = 0; t < 50 && !b; t++) begin
      @(negedge aclk);
      {g, w, b} = {awready, wready, bvalid};
      @(posedge aclk);
      if (g) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      if (b) `CHK("bresp", er, bresp)
    end
  endtask : wr
  // bus read; expected answer is queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    int t;
    logic g, r;
    rq.push_back({er, ex});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 1'b0;
    for (t = 0; t < 50 && !r; t++) begin
      @(negedge aclk);
      {g, r} = {arready, rvalid};
      @(posedge aclk);
      if (g) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask : rd
  // one-cycle time-base pulse: 0 period, 1 rise, 2 fall
  task automatic pulse(input int k);
    @(posedge aclk);
    period_evt <= (k == 0);
    rise_evt <= (k == 1);
    fall_evt <= (k == 2);
    @(posedge aclk);
    {period_evt, rise_evt, fall_evt} <= 3'h0;
  endtask : pulse
  // cycles from outgoing low to incoming high
  task automatic swing(input int off, input int on, input int ex);
    int t;
    for (t = 0; o[off] && t < 400; t++) @(negedge aclk);
    for (d = 0; !o[on] && d < 400; d++) @(negedge aclk);
    if (ex >= 0) `CHK("dead band", ex, d)
  endtask : swing
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // read answers compared as they are accepted
  always @(negedge aclk) begin
    if (rvalid && rready) begin
      rx = rq.pop_front();
      `CHK("rresp", rx[33:32], rresp)
      `CHK("rdata", rx[31:0], rdata)
    end
  end
  // watchdog
  initial begin
    #(25 * 80000);
    err_count++;
    test_done();
  end
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, period_evt, rise_evt, fall_evt} = 8'h00;
    {awaddr, araddr, wstrb, wdata} = 52'h0;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ppc_pkg::OFF_DBR, 32'h0, ppc_pkg::RESP_OKAY);
    rd(ppc_pkg::OFF_DBF, 32'h0, ppc_pkg::RESP_OKAY);
    rd(ppc_pkg::OFF_FFA, 32'h0, ppc_pkg::RESP_OKAY);
    repeat (32) seed = lfsr(seed);
    wr(ppc_pkg::OFF_DBR, seed, 4'hf, ppc_pkg::RESP_OKAY);
    wr(ppc_pkg::OFF_DBF, seed >> 8, 4'hf, ppc_pkg::RESP_OKAY);
    wr(ppc_pkg::OFF_FFA, seed >> 16, 4'hf, ppc_pkg::RESP_OKAY);
    wr(ppc_pkg::OFF_DBR, ~seed, 4'h0, ppc_pkg::RESP_OKAY);
    rd(ppc_pkg::OFF_DBR, {24'h0, seed[7:0]}, ppc_pkg::RESP_OKAY);
    rd(ppc_pkg::OFF_DBF, {24'h0, seed[15:8]}, ppc_pkg::RESP_OKAY);
    rd(ppc_pkg::OFF_FFA, {28'h0, seed[19:16]}, ppc_pkg::RESP_OKAY);
    wr(8'h20, seed, 4'hf, ppc_pkg::RESP_SLVERR);
    rd(8'h20, 32'h0, ppc_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(ppc_pkg::OFF_DBR, 32'h3, 4'hf, ppc_pkg::RESP_OKAY);
    wr(ppc_pkg::OFF_DBF, 32'h2, 4'hf, ppc_pkg::RESP_OKAY);
    wr(ppc_pkg::OFF_FFA, 32'h0, 4'hf, ppc_pkg::RESP_OKAY);
    // each prescale; dead bands off in the last pass
    for (int p = 0; p < 4; p++) begin
      wr(ppc_pkg::OFF_CTRL, 32'h0, 4'hf, ppc_pkg::RESP_OKAY);
      // pair state clears one edge after the write, the output flops one more
      repeat (2) @(negedge aclk);
      `CHK("disabled outputs", 4'h0, o)
      wr(ppc_pkg::OFF_CTRL, {26'h0, 2'(p), 1'b0, {2{p < 3}}, 1'b1}, 4'hf, ppc_pkg::RESP_OKAY);
      for (int k = 0; k < 4; k++) begin
        pulse(0);
        pulse(1);
        swing(1 + 2 * (k % 2), 2 * (k % 2), k < 2 ? -1 : (p < 3 ? 3 << p : 0));
        `CHK("idle primary", 1'b0, o[2 - 2 * (k % 2)])
        pulse(2);
        swing(2 * (k % 2), 1 + 2 * (k % 2), p < 3 ? 2 << p : 0);
      end
      $display("test prescale %0d done", p);
    end
    `CHK("shoot through", 1'b0, shoot)
    test_done();
  end
endmodule : tb
